// >>> core/cbfs_pkg.sv
// Package of constants for the CAN bus fault supervisor
package cbfs_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TX_DOM_TO_MIN_US = 800;
  localparam int unsigned TX_DOM_TO_MAX_US = 1280;
  localparam int unsigned BUS_DOM_TO_MIN_US = 800;
  localparam int unsigned BUS_DOM_TO_MAX_US = 1280;
  // Stuck recessive windows use 1280 us, the top of the dominant span; the dominant ones count the 800 us minimum
  localparam int unsigned REC_TO_US = 1280;
  localparam int unsigned TX_DOM_CYC = TX_DOM_TO_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned BUS_DOM_CYC =
    BUS_DOM_TO_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned REC_CYC = REC_TO_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 16;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] ADDR_FAULT = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // ==========================================================
  // Fault field positions
  localparam int unsigned BIT_TX_DOM = 16;
  localparam int unsigned BIT_BUS_REC = 17;
  localparam int unsigned BIT_BUS_DOM = 18;
  localparam int unsigned BIT_RX_REC = 19;

  // Control field positions
  localparam int unsigned CTRL_ON = 0;
  localparam int unsigned CTRL_ERR_EN = 1;
  localparam int unsigned CTRL_LOOP = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // Stuck level for the watchdog units
  localparam logic DOMINANT = 1'b0;
  localparam logic RECESSIVE = 1'b1;

endpackage : cbfs_pkg

// >>> core/cbfs_stuck_timer.sv
// Stuck-level timer: flags a signal held at one level too long
module cbfs_stuck_timer #(
  parameter int unsigned LIMIT = 16000,
  parameter logic LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Watch
  input wire logic enable,
  input wire logic sig,
  output logic stuck
);
  import cbfs_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  // ==========================================================
  // Counter
  // restart and hold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (!enable || sig != LEVEL) begin
      cnt_q <= '0;
    end else if (cnt_q != LIMIT[CNT_W-1:0]) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign stuck = cnt_q == LIMIT[CNT_W-1:0];

endmodule : cbfs_stuck_timer

// >>> core/cbfs_top.sv
// CAN bus fault supervisor with AHB-Lite register slave
// Function
// - TX dominant timeout disables TX, sets bit16
// - Bus stuck recessive disables TX, sets bit17
// - Bus stuck dominant sets bit18 only
// - Bus dominant declared after 800-1280 us
// - RX stuck recessive disables TX, sets bit19
// - Fault read clears flags; TX re-enables
// - Disable pin blocks TX; receiver keeps listening
// - Loop bit routes TX input to RX
module cbfs_top #(
  parameter int unsigned TX_DOM_LIMIT = cbfs_pkg::TX_DOM_CYC,
  parameter int unsigned BUS_DOM_LIMIT = cbfs_pkg::BUS_DOM_CYC,
  parameter int unsigned REC_LIMIT = cbfs_pkg::REC_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN side
  input wire logic can_tx_input,
  input wire logic bus_rx,
  input wire logic transmitter_disable_pin,
  output logic bus_tx,
  output logic can_rx_output,
  // Interrupt
  output logic irq
);
  import cbfs_pkg::*;

  logic [3:0] fault_q;
  logic [3:0] mask_q;
  logic [2:0] ctrl_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic bus_tx_q;
  logic can_rx_q;
  logic irq_q;
  logic [3:0] ev;
  logic det_en;
  logic rx_internal;
  logic tx_block;
  logic acc;
  logic fault_rd;
  logic hreadyout_q;
  logic hresp_q;

  // ==========================================================
  // Read word assembly
  function automatic logic [31:0] read_word(
    input logic [7:0] a,
    input logic [3:0] flags,
    input logic [3:0] mask,
    input logic [2:0] ctrl,
    input logic [1:0] stat
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      ADDR_FAULT: w[BIT_RX_REC:BIT_TX_DOM] = flags;
      ADDR_MASK: w[BIT_RX_REC:BIT_TX_DOM] = mask;
      ADDR_CTRL: w[2:0] = ctrl;
      ADDR_STAT: w[1:0] = stat;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // ==========================================================
  // Detection enable and timers
  // gate detection
  assign det_en = ctrl_q[CTRL_ON] & ctrl_q[CTRL_ERR_EN];
  assign rx_internal = ctrl_q[CTRL_LOOP] ? can_tx_input : bus_rx;

  cbfs_stuck_timer #(.LIMIT(TX_DOM_LIMIT), .LEVEL(DOMINANT)) u_txdom (
    .core_clk(core_clk), .arst_n(arst_n), .enable(det_en),
    .sig(can_tx_input), .stuck(ev[0]));
  cbfs_stuck_timer #(.LIMIT(REC_LIMIT), .LEVEL(RECESSIVE)) u_busrec (
    .core_clk(core_clk), .arst_n(arst_n), .enable(det_en),
    .sig(bus_rx), .stuck(ev[1]));
  cbfs_stuck_timer #(.LIMIT(BUS_DOM_LIMIT), .LEVEL(DOMINANT)) u_busdom (
    .core_clk(core_clk), .arst_n(arst_n), .enable(det_en),
    .sig(bus_rx), .stuck(ev[2]));
  cbfs_stuck_timer #(.LIMIT(REC_LIMIT), .LEVEL(RECESSIVE)) u_rxrec (
    .core_clk(core_clk), .arst_n(arst_n), .enable(det_en),
    .sig(can_rx_q), .stuck(ev[3]));

  // ==========================================================
  // AHB-Lite address phase
  assign acc = hsel & hready & htrans[1];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= acc & hwrite;
      rd_q <= acc & ~hwrite;
    end
  end

  // Address held for the data phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= 8'h00;
    end else if (acc) begin
      addr_q <= haddr;
    end
  end

  assign fault_rd = rd_q & (addr_q == ADDR_FAULT);

  // ==========================================================
  // Fault flags
  // read clears, set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 4'h0;
    end else begin
      fault_q <= (fault_rd ? 4'h0 : fault_q) | ev;
    end
  end

  // ==========================================================
  // Writable registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= MASK_RST;
    end else if (wr_q && addr_q == ADDR_MASK) begin
      mask_q <= hwdata[BIT_RX_REC:BIT_TX_DOM];
    end
  end

  // Control bits
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_q && addr_q == ADDR_CTRL) begin
      ctrl_q <= hwdata[2:0];
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= 32'h0000_0000;
      if (acc & ~hwrite) begin
        hrdata_q <= read_word(haddr, fault_q | ev, mask_q, ctrl_q,
                              {det_en, tx_block});
      end
    end
  end

  // ==========================================================
  // Bus response, always ready and OKAY
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ==========================================================
  // Transmitter and receive path
  // disabling faults; excluded
  assign tx_block = fault_q[0] | fault_q[1] | fault_q[3] |
                    transmitter_disable_pin;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_tx_q <= RECESSIVE;
    end else begin
      bus_tx_q <= tx_block ? RECESSIVE : can_tx_input;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      can_rx_q <= RECESSIVE;
    end else begin
      can_rx_q <= rx_internal;
    end
  end

  // ==========================================================
  // Interrupt, a set mask bit silences its flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((fault_q | ev) & ~mask_q & ~({4{fault_rd}} & ~ev));
    end
  end

  assign bus_tx = bus_tx_q;
  assign can_rx_output = can_rx_q;
  assign irq = irq_q;

endmodule : cbfs_top

// >>> bench/cbfs_bus_model.sv
// CAN bus model: wired bus with stuck-level faults
module cbfs_bus_model (
  // Driver and faults
  input wire logic bus_tx,
  input wire logic force_dom,
  input wire logic force_rec,
  // Receiver
  output logic bus_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  assign bus_rx = force_rec | (bus_tx & !force_dom);
endmodule : cbfs_bus_model

// >>> bench/cbfs_top_sva.sv
// Checker of the fault supervisor ports
module cbfs_chk #(
  parameter int unsigned TX_DOM_LIMIT = 16000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // CAN side
  input wire logic can_tx_input,
  input wire logic bus_rx,
  input wire logic transmitter_disable_pin,
  input wire logic bus_tx,
  input wire logic can_rx_output
);
  import cbfs_pkg::*;
  logic wr_q, rd;
  logic [2:0] ctl_q;
  int unsigned cnt_q;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Control shadow
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      ctl_q <= 3'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == ADDR_CTRL;
      if (wr_q) ctl_q <= hwdata[2:0];
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 0;
    else if (ctl_q[1:0] == 2'h3 && !can_tx_input) cnt_q <= cnt_q + 1;
    else cnt_q <= 0;
  end
  a_tx_rec_pass: assert property (can_tx_input |=> bus_tx)
    else $error("bus_tx dominant on recessive input");
  a_pin_blocks: assert property (transmitter_disable_pin |=> bus_tx)
    else $error("bus_tx dominant while disabled");
  a_loop_route: assert property (ctl_q[2] |=>
    can_rx_output == $past(can_tx_input)) else $error("loop route wrong");
  a_rx_listen: assert property (!ctl_q[2] |=>
    can_rx_output == $past(bus_rx)) else $error("rx output wrong");
  a_tx_dom_stop: assert property (cnt_q >= TX_DOM_LIMIT + 4 |-> bus_tx)
    else $error("bus_tx not blocked after timeout");
  a_fault_bits: assert property (rd && haddr == ADDR_FAULT |=>
    hrdata[15:0] == 16'h0 && hrdata[31:20] == 12'h0)
    else $error("fault read outside flag field");
  a_void_zero: assert property (rd && haddr >= 8'h10 |=>
    hrdata == 32'h0) else $error("unmapped read not zero");
  a_detect_stat: assert property (rd && haddr == ADDR_STAT |=>
    hrdata[1] == (($past(ctl_q) | 3'h4) == 3'h7))
    else $error("detection status wrong");
endmodule : cbfs_chk
bind cbfs_top cbfs_chk #(.TX_DOM_LIMIT(TX_DOM_LIMIT)) u_chk (
  .core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .can_tx_input, .bus_rx, .transmitter_disable_pin, .bus_tx,
  .can_rx_output
);

// >>> bench/cbfs_top_test.sv
// Testbench for the CAN bus fault supervisor
module cbfs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cbfs_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, hwrite = 1'b0, v = 1'b1;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, bus_tx, bus_rx, can_rx_output, irq;
  logic can_tx_input = 1'b1, transmitter_disable_pin = 1'b0;
  logic force_dom = 1'b0, force_rec = 1'b0;
  logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  int err_count = 0, compares = 0, seed = 32'h8655;
  always #25 core_clk = ~core_clk;
  cbfs_top #(.TX_DOM_LIMIT(20), .BUS_DOM_LIMIT(40), .REC_LIMIT(60)) u_dut (
    .core_clk, .arst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .can_tx_input, .bus_rx, .transmitter_disable_pin, .bus_tx,
    .can_rx_output, .irq
  );
  cbfs_bus_model u_bus (.bus_tx, .force_dom, .force_rec, .bus_rx);
  // ==========================================
  // Tasks
  task automatic bus(input logic wr, input logic [7:0] a, input int d);
    @(posedge core_clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= 32'(d);
    do @(posedge core_clk); while (!hreadyout);
    q = hrdata;
  endtask : bus
  task automatic cmp(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic after(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : after
  function automatic logic [31:0] flag(input int b);
    return 32'h1 << b;
  endfunction : flag
  task automatic close_out;
    $display("Counts: %0d compares, %0d errors", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    #200000;
    err_count++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (adr[i]) begin
      bus(1'b0, adr[i], 0);
      cmp("reg", 32'h0, q);
      cmp("hresp", 32'h0, 32'(hresp));
      cmp("hreadyout", 32'h1, 32'(hreadyout));
    end
    bus(1'b1, ADDR_CTRL, 3);
    for (int i = 0; i < 40; i++) begin
      v = i[0] ? 1'($random(seed)) : !v;
      can_tx_input <= v;
      after(2);
      cmp("bus_tx", 32'(v), 32'(bus_tx));
      cmp("rx", 32'(v), 32'(can_rx_output));
      @(posedge core_clk);
    end
    $display("done random");
    force_rec <= 1'b1;
    can_tx_input <= 1'b0;
    bus(1'b1, ADDR_CTRL, 5);
    after(1);
    cmp("loop", 32'h0, 32'(can_rx_output));
    bus(1'b1, ADDR_CTRL, 1);
    transmitter_disable_pin <= 1'b1;
    after(1);
    cmp("rx", 32'h1, 32'(can_rx_output));
    cmp("pin", 32'h1, 32'(bus_tx));
    @(posedge core_clk);
    transmitter_disable_pin <= 1'b0;
    force_rec <= 1'b0;
    after(30);
    cmp("idle", 32'h0, 32'(bus_tx));
    $display("done loop");
    bus(1'b1, ADDR_CTRL, 3);
    after(30);
    cmp("tx stop", 32'h1, 32'(bus_tx));
    @(posedge core_clk);
    can_tx_input <= 1'b1;
    bus(1'b0, ADDR_FAULT, 0);
    cmp("fault", flag(BIT_TX_DOM), q);
    bus(1'b0, ADDR_FAULT, 0);
    cmp("clear", 32'h0, q);
    can_tx_input <= 1'b0;
    after(2);
    cmp("restart", 32'h0, 32'(bus_tx));
    @(posedge core_clk);
    can_tx_input <= 1'b1;
    force_dom <= 1'b1;
    bus(1'b0, ADDR_FAULT, 0);
    cyc_dom: begin
      repeat (28) @(posedge core_clk);
    end
    bus(1'b0, ADDR_FAULT, 0);
    cmp("early", 32'h0, q);
    repeat (20) @(posedge core_clk);
    bus(1'b0, ADDR_FAULT, 0);
    cmp("bus dom", flag(BIT_BUS_DOM), q);
    can_tx_input <= 1'b0;
    after(1);
    cmp("tx kept", 32'h0, 32'(bus_tx));
    @(posedge core_clk);
    can_tx_input <= 1'b1;
    force_dom <= 1'b0;
    bus(1'b1, ADDR_CTRL, 1);
    bus(1'b0, ADDR_FAULT, 0);
    $display("done dominant");
    force_rec <= 1'b1;
    bus(1'b1, ADDR_CTRL, 3);
    after(70);
    cmp("irq", 32'h1, 32'(irq));
    bus(1'b1, ADDR_MASK, 32'h000f0000);
    after(1);
    cmp("masked", 32'h0, 32'(irq));
    bus(1'b1, ADDR_MASK, 0);
    can_tx_input <= 1'b0;
    after(2);
    cmp("tx off", 32'h1, 32'(bus_tx));
    @(posedge core_clk);
    can_tx_input <= 1'b1;
    force_rec <= 1'b0;
    bus(1'b1, ADDR_CTRL, 1);
    bus(1'b0, ADDR_FAULT, 0);
    cmp("rec", flag(BIT_BUS_REC) | flag(BIT_RX_REC), q);
    bus(1'b0, ADDR_FAULT, 0);
    cmp("clear", 32'h0, q);
    $display("done recessive");
    close_out;
  end
endmodule : cbfs_top_test
